// ---- src/kr_keypad_entry_reporter.sv ----
// Keypad entry, display echo, host reporting and reader notices
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module kr_keypad_entry_reporter #(
   parameter logic [31:0] TIMEOUT_CYC = kr_pkg::TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Avalon-MM register slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Keypad scanner
   input wire logic key_valid,
   input wire logic [4:0] key_index,
   // Card reader
   input wire logic card_valid,
   input wire logic card_bad,
   input wire logic [7:0] card_data,
   // Serial receiver and transmitter
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic [1:0] baud_sel,
   // Display
   output logic disp_we,
   output logic disp_clear,
   output logic [4:0] disp_pos,
   output logic [7:0] disp_char,
   output logic page_show,
   output logic [3:0] page_num,
   // Beeper
   output logic beep,
   // Settings storage
   output logic nv_load_req,
   input wire logic nv_valid,
   input wire logic [7:0] nv_rdata,
   output logic nv_store,
   output logic [7:0] nv_wdata
);
   typedef enum logic [1:0] {KR_LOAD, KR_IDLE, KR_TX} kr_state_e;

   typedef struct packed {
      kr_state_e state;
      logic buffered;
      logic masked;
      logic kp_en;
      logic rd_en;
      logic [1:0] baud;
      logic [5:0] count;
      logic [31:0][7:0] line;
      logic [5:0] idx;
      logic [5:0] len;
      logic src_buf;
      logic [7:0] mb0;
      logic [7:0] mb1;
      logic [31:0] timer;
      logic resp_pend;
      logic [7:0] resp;
      logic cp_in;
      logic [1:0] cp_cnt;
      logic cp_ovf;
      logic [2:0][7:0] cmd;
      logic tx_valid;
      logic [7:0] tx_data;
      logic disp_we;
      logic disp_clear;
      logic [4:0] disp_pos;
      logic [7:0] disp_char;
      logic beep;
      logic page_show;
      logic nv_store;
      logic [7:0] nv_wdata;
      logic bus_ack;
      logic [31:0] rdata;
   } kr_st_s;

   kr_st_s st;
   kr_st_s next_st;

   function automatic logic [7:0] key_ascii(input logic [4:0] k);
      logic [7:0] a;
      a = 8'h00;
      if (k <= 5'h09) begin
         a = kr_pkg::DIGIT_BASE + {3'h0, k};
      end else if (k <= kr_pkg::IDX_FUNC_LAST) begin
         a = kr_pkg::FUNC_BASE + {3'h0, k - kr_pkg::IDX_FUNC_ONE};
      end else begin
         case (k)
            kr_pkg::IDX_DOT: a = kr_pkg::DOT_CODE;
            kr_pkg::IDX_BACKSPACE: a = kr_pkg::BACKSPACE_CODE;
            kr_pkg::IDX_ERASE_ALL: a = kr_pkg::ERASE_ALL_CODE;
            kr_pkg::IDX_SUBMIT: a = kr_pkg::SUBMIT_CODE;
            default: a = 8'h00;
         endcase
      end
      return a;
   endfunction

   function automatic logic [7:0] settings(input kr_st_s s);
      logic [7:0] b;
      b = 8'h00;
      b[kr_pkg::SB_BAUD +: 2] = s.baud;
      b[kr_pkg::SB_MODE] = s.buffered;
      b[kr_pkg::SB_DISP] = s.masked;
      b[kr_pkg::SB_READER] = s.rd_en;
      b[kr_pkg::SB_KEYPAD] = s.kp_en;
      return b;
   endfunction

   always_comb begin
      logic [7:0] code;
      logic [7:0] a1;
      logic [7:0] a2;
      logic ok;
      code = key_ascii(key_index);
      a1 = st.cmd[1];
      a2 = st.cmd[2];
      ok = 1'b0;
      next_st = st;
      next_st.disp_we = 1'b0;
      next_st.disp_clear = 1'b0;
      next_st.beep = 1'b0;
      next_st.page_show = 1'b0;
      next_st.nv_store = 1'b0;
      if (st.tx_valid && tx_ready) begin
         next_st.tx_valid = 1'b0;
      end

      // Command parser on the serial receive stream
      if (rx_valid) begin
         if (rx_data == kr_pkg::FRAME_START) begin
            next_st.cp_in = 1'b1;
            next_st.cp_cnt = 2'h0;
            next_st.cp_ovf = 1'b0;
         end else if (st.cp_in && rx_data == kr_pkg::FRAME_END) begin
            next_st.cp_in = 1'b0;
            if (!st.cp_ovf) begin
               case (st.cmd[0])
                  kr_pkg::OP_ERASE: begin
                     ok = (st.cp_cnt == 2'h1);
                     if (ok) begin
                        next_st.count = 6'h00;
                        next_st.disp_clear = 1'b1;
                     end
                  end
                  kr_pkg::OP_KEYPAD, kr_pkg::OP_READER: begin
                     ok = (st.cp_cnt == 2'h2) && (a1 == kr_pkg::ARG_ON || a1 == kr_pkg::ARG_OFF);
                     if (ok && st.cmd[0] == kr_pkg::OP_KEYPAD) begin
                        next_st.kp_en = a1[0];
                     end else if (ok) begin
                        next_st.rd_en = a1[0];
                     end
                  end
                  kr_pkg::OP_PARAM: begin
                     if (st.cp_cnt == 2'h3 && a2 >= kr_pkg::ARG_OFF) begin
                        case (a1)
                           kr_pkg::PARAM_BAUD: begin
                              ok = (a2 <= kr_pkg::ARG_BAUD_MAX);
                              if (ok) begin
                                 next_st.baud = a2[1:0];
                              end
                           end
                           kr_pkg::PARAM_MODE: begin
                              ok = (a2 <= kr_pkg::ARG_ON);
                              if (ok) begin
                                 next_st.buffered = a2[0];
                              end
                           end
                           kr_pkg::PARAM_DISP: begin
                              ok = (a2 <= kr_pkg::ARG_ON);
                              if (ok) begin
                                 next_st.masked = a2[0];
                              end
                           end
                           default: ok = 1'b0;
                        endcase
                     end
                  end
                  default: ok = 1'b0;
               endcase
            end
            // Only one answer is held; a newer frame overwrites an unsent one
            next_st.resp_pend = 1'b1;
            next_st.resp = ok ? kr_pkg::ANS_ACK : kr_pkg::ANS_NACK;
            if (ok && st.cmd[0] != kr_pkg::OP_ERASE) begin
               next_st.nv_store = 1'b1;
               next_st.nv_wdata = settings(next_st);
            end
         end else if (st.cp_in) begin
            if (st.cp_cnt == 2'h3) begin
               next_st.cp_ovf = 1'b1;
            end else begin
               next_st.cmd[st.cp_cnt] = rx_data;
               next_st.cp_cnt = st.cp_cnt + 2'h1;
            end
         end
      end

      // Register slave: one wait cycle, then the answer
      next_st.bus_ack = (avs_read || avs_write) && !st.bus_ack;
      if ((avs_read || avs_write) && !st.bus_ack) begin
         next_st.rdata = 32'h0000_0000;
         case (avs_address)
            kr_pkg::REG_CTRL: begin
               next_st.rdata[kr_pkg::CT_BUFFERED] = st.buffered;
               next_st.rdata[kr_pkg::CT_MASKED] = st.masked;
               next_st.rdata[kr_pkg::CT_KEYPAD] = st.kp_en;
               next_st.rdata[kr_pkg::CT_READER] = st.rd_en;
               next_st.rdata[kr_pkg::CT_BAUD +: 2] = st.baud;
            end
            kr_pkg::REG_STATUS: begin
               next_st.rdata[5:0] = st.count;
               next_st.rdata[kr_pkg::STS_BUSY] = (st.state != KR_IDLE);
               next_st.rdata[kr_pkg::STS_RESP] = st.resp_pend;
            end
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && st.bus_ack && avs_address == kr_pkg::REG_CTRL) begin
         next_st.buffered = avs_writedata[kr_pkg::CT_BUFFERED];
         next_st.masked = avs_writedata[kr_pkg::CT_MASKED];
         next_st.kp_en = avs_writedata[kr_pkg::CT_KEYPAD];
         next_st.rd_en = avs_writedata[kr_pkg::CT_READER];
         next_st.baud = avs_writedata[kr_pkg::CT_BAUD +: 2];
         next_st.nv_store = 1'b1;
         next_st.nv_wdata = settings(next_st);
      end

      case (st.state)
         KR_LOAD: begin
            if (nv_valid) begin
               next_st.baud = nv_rdata[kr_pkg::SB_BAUD +: 2];
               next_st.buffered = nv_rdata[kr_pkg::SB_MODE];
               next_st.masked = nv_rdata[kr_pkg::SB_DISP];
               next_st.kp_en = 1'b1;
               next_st.rd_en = 1'b1;
               next_st.beep = 1'b1;
               next_st.page_show = 1'b1;
               next_st.state = KR_IDLE;
            end
         end
         KR_IDLE: begin
            next_st.idx = 6'h00;
            next_st.src_buf = 1'b0;
            if (st.count == 6'h00) begin
               next_st.timer = 32'h0000_0000;
            end else begin
               next_st.timer = st.timer + 32'h0000_0001;
            end
            if (st.resp_pend) begin
               next_st.resp_pend = 1'b0;
               next_st.mb0 = st.resp;
               next_st.len = 6'h01;
               next_st.state = KR_TX;
            end else if (card_valid && st.rd_en) begin
               if (card_bad) begin
                  next_st.mb0 = kr_pkg::CARD_ERR_NOTICE;
                  next_st.len = 6'h01;
               end else begin
                  next_st.mb0 = kr_pkg::CARD_TAG;
                  next_st.mb1 = card_data;
                  next_st.len = 6'h02;
                  next_st.beep = 1'b1;
               end
               next_st.state = KR_TX;
            end else if (key_valid && st.kp_en && code != 8'h00) begin
               next_st.timer = 32'h0000_0000;
               if (!st.buffered) begin
                  next_st.mb0 = code;
                  next_st.len = 6'h01;
                  next_st.state = KR_TX;
               end
               case (code)
                  kr_pkg::BACKSPACE_CODE: begin
                     if (st.count != 6'h00) begin
                        next_st.count = st.count - 6'h01;
                        next_st.disp_we = 1'b1;
                        next_st.disp_pos = 5'(st.count - 6'h01);
                        next_st.disp_char = kr_pkg::BLANK_CHAR;
                     end
                  end
                  kr_pkg::ERASE_ALL_CODE: begin
                     next_st.count = 6'h00;
                     next_st.disp_clear = 1'b1;
                  end
                  kr_pkg::SUBMIT_CODE: begin
                     if (st.buffered && st.count != 6'h00) begin
                        next_st.src_buf = 1'b1;
                        next_st.len = st.count;
                        next_st.state = KR_TX;
                     end
                  end
                  default: begin
                     if (st.count < 6'(kr_pkg::MAX_KEYS)) begin
                        next_st.line[5'(st.count)] = code;
                        next_st.count = st.count + 6'h01;
                        next_st.disp_clear = (st.count == 6'h00);
                        next_st.disp_we = 1'b1;
                        next_st.disp_pos = 5'(st.count);
                        next_st.disp_char = st.masked ? kr_pkg::MASK_CHAR : code;
                     end
                  end
               endcase
            end else if (st.count != 6'h00 && st.timer >= TIMEOUT_CYC - 32'h0000_0001) begin
               next_st.count = 6'h00;
               next_st.disp_clear = 1'b1;
               next_st.mb0 = kr_pkg::TIMEOUT_NOTICE;
               next_st.len = 6'h01;
               next_st.state = KR_TX;
            end
         end
         KR_TX: begin
            // Key and card events are not taken while a message is in flight; host frames are still parsed
            if (!st.tx_valid || tx_ready) begin
               if (st.idx < st.len) begin
                  next_st.tx_valid = 1'b1;
                  if (st.src_buf) begin
                     next_st.tx_data = st.line[5'(st.idx)];
                  end else begin
                     next_st.tx_data = (st.idx == 6'h00) ? st.mb0 : st.mb1;
                  end
                  next_st.idx = st.idx + 6'h01;
               end else begin
                  next_st.state = KR_IDLE;
                  if (st.src_buf) begin
                     next_st.count = 6'h00;
                     next_st.disp_clear = 1'b1;
                  end
               end
            end
         end
         default: next_st.state = KR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
         st.state <= KR_LOAD;
         st.kp_en <= 1'b1;
         st.rd_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !st.bus_ack;
   assign avs_readdata = st.rdata;
   assign tx_valid = st.tx_valid;
   assign tx_data = st.tx_data;
   assign baud_sel = st.baud;
   assign disp_we = st.disp_we;
   assign disp_clear = st.disp_clear;
   assign disp_pos = st.disp_pos;
   assign disp_char = st.disp_char;
   assign page_show = st.page_show;
   assign page_num = kr_pkg::START_PAGE;
   assign beep = st.beep;
   assign nv_load_req = (st.state == KR_LOAD);
   assign nv_store = st.nv_store;
   assign nv_wdata = st.nv_wdata;
endmodule

// ---- src/kr_pkg.sv ----
// Constants shared by the keypad entry reporter
package kr_pkg;
   // Clock and inactivity timeout
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned TIMEOUT_S = 10;
   localparam logic [31:0] TIMEOUT_CYC = 32'(64'(TIMEOUT_S) * 64'(CLK_HZ));
   // Entry and page limits
   localparam int unsigned MAX_KEYS = 32;
   localparam int unsigned PAGE_COUNT = 12;
   localparam logic [3:0] START_PAGE = 4'h1;
   // Key codes
   localparam logic [7:0] DIGIT_BASE = 8'h30;
   localparam logic [7:0] FUNC_BASE = 8'h41;
   localparam logic [7:0] DOT_CODE = 8'h3E;
   localparam logic [7:0] BACKSPACE_CODE = 8'h08;
   localparam logic [7:0] ERASE_ALL_CODE = 8'h1B;
   localparam logic [7:0] SUBMIT_CODE = 8'h0D;
   localparam logic [7:0] MASK_CHAR = 8'h2A;
   localparam logic [7:0] BLANK_CHAR = 8'h20;
   // Keypad scanner indices
   localparam logic [4:0] IDX_FUNC_ONE = 5'h0A;
   localparam logic [4:0] IDX_FUNC_LAST = 5'h0F;
   localparam logic [4:0] IDX_DOT = 5'h10;
   localparam logic [4:0] IDX_BACKSPACE = 5'h11;
   localparam logic [4:0] IDX_ERASE_ALL = 5'h12;
   localparam logic [4:0] IDX_SUBMIT = 5'h13;
   // Serial framing and answers
   localparam logic [7:0] FRAME_START = 8'h02;
   localparam logic [7:0] FRAME_END = 8'h03;
   localparam logic [7:0] ANS_ACK = 8'h06;
   localparam logic [7:0] ANS_NACK = 8'h15;
   localparam logic [7:0] OP_ERASE = 8'h43;
   localparam logic [7:0] OP_KEYPAD = 8'h4B;
   localparam logic [7:0] OP_READER = 8'h4D;
   localparam logic [7:0] OP_PARAM = 8'h50;
   localparam logic [7:0] ARG_OFF = 8'h30;
   localparam logic [7:0] ARG_ON = 8'h31;
   localparam logic [7:0] PARAM_BAUD = 8'h31;
   localparam logic [7:0] PARAM_MODE = 8'h32;
   localparam logic [7:0] PARAM_DISP = 8'h33;
   localparam logic [7:0] ARG_BAUD_MAX = 8'h33;
   // Notice bytes
   localparam logic [7:0] TIMEOUT_NOTICE = 8'h54;
   localparam logic [7:0] CARD_ERR_NOTICE = 8'h45;
   localparam logic [7:0] CARD_TAG = 8'h52;
   // Settings byte layout (also the stored form)
   localparam int unsigned SB_BAUD = 0;
   localparam int unsigned SB_MODE = 2;
   localparam int unsigned SB_DISP = 3;
   localparam int unsigned SB_READER = 4;
   localparam int unsigned SB_KEYPAD = 5;
   // Register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int unsigned CT_BUFFERED = 0;
   localparam int unsigned CT_MASKED = 1;
   localparam int unsigned CT_KEYPAD = 2;
   localparam int unsigned CT_READER = 3;
   localparam int unsigned CT_BAUD = 4;
   localparam int unsigned STS_BUSY = 8;
   localparam int unsigned STS_RESP = 9;
endpackage

// ---- verification/kr_keypad_entry_reporter_checker.sv ----
// Port assertions for the keypad entry reporter
module kr_keypad_entry_reporter_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Serial transmitter
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic [1:0] baud_sel,
   // Start-up, beeper and storage
   input wire logic page_show,
   input wire logic [3:0] page_num,
   input wire logic beep,
   input wire logic nv_load_req,
   input wire logic nv_valid,
   input wire logic nv_store,
   input wire logic [7:0] nv_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic ctrl_wr;
   logic [31:0] wd_q;
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == kr_pkg::REG_CTRL;
   // Write data of the previous cycle, for checks one cycle after a write
   always_ff @(posedge clk) begin
      wd_q <= avs_writedata;
   end
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte dropped or changed before taken");
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access stalled more than one cycle");
   AST_LOAD_WAIT: assert property (nv_load_req && !nv_valid |=> nv_load_req)
      else $error("settings load left without stored data");
   AST_START_SEQ: assert property (nv_load_req && nv_valid |=> beep && page_show && !nv_load_req ##1 !page_show)
      else $error("start-up beep and page missing");
   AST_START_PAGE: assert property (page_show |-> page_num == kr_pkg::START_PAGE)
      else $error("start page is not the first page");
   AST_STORE: assert property (ctrl_wr |=> nv_store && nv_wdata == {2'b00, wd_q[2], wd_q[3], wd_q[1], wd_q[0], wd_q[5:4]})
      else $error("changed settings not stored");
   AST_BAUD: assert property (ctrl_wr |=> baud_sel == wd_q[5:4])
      else $error("baud setting not applied");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address != kr_pkg::REG_CTRL && avs_address != kr_pkg::REG_STATUS |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   COV_TX: cover property (tx_valid && tx_ready);
   COV_BEEP: cover property (beep && !page_show);
   COV_STORE: cover property (nv_store);
endmodule

bind kr_keypad_entry_reporter kr_keypad_entry_reporter_checker chk_u (.clk, .arst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_valid, .tx_data,
   .tx_ready, .baud_sel, .page_show, .page_num, .beep, .nv_load_req, .nv_valid, .nv_store, .nv_wdata);

// ---- verification/kr_host_model.sv ----
// Host computer on the serial side: takes bytes with stalls, sends command frames
module kr_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Device transmitter
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Device receiver
   output logic rx_valid,
   output logic [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 26;
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end
   // Random stalls make the device hold each byte for a varying time
   always @(posedge clk) begin
      tx_ready <= arst_n && (($random(seed) & 3) != 0);
   end
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~b;
   endtask
   task automatic send_cmd(input logic [7:0] op, arg, arg2, input int n_args);
      send_byte(kr_pkg::FRAME_START);
      send_byte(op);
      if (n_args > 0) send_byte(arg);
      if (n_args > 1) send_byte(arg2);
      send_byte(kr_pkg::FRAME_END);
   endtask
endmodule

// ---- verification/kr_keypad_entry_reporter_tb.sv ----
// Self-checking bench for the keypad entry reporter
module kr_keypad_entry_reporter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Short inactivity limit keeps the run brief
   localparam logic [31:0] TMO = 32'd200;
   logic clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, key_valid = 1'b0;
   logic card_valid = 1'b0, card_bad = 1'b0, nv_valid = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [4:0] key_index = 5'h00, disp_pos;
   logic [7:0] card_data = 8'h00, nv_rdata = 8'h00, rx_data, tx_data, disp_char, nv_wdata;
   logic avs_waitrequest, rx_valid, tx_valid, tx_ready, disp_we, disp_clear, page_show, beep;
   logic nv_load_req, nv_store;
   logic [3:0] page_num;
   logic [1:0] baud_sel;
   int errors = 0, n_checks = 0, seed = 26, cycles = 0, cnt = 0;
   bit buffered = 1'b0, masked = 1'b0, kp_on = 1'b1;
   logic [7:0] exp_tx[$], line[$];
   logic [13:0] exp_disp[$];
   always #2 clk = ~clk;
   kr_keypad_entry_reporter #(.TIMEOUT_CYC(TMO)) dut_u (.clk, .arst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .key_valid, .key_index,
      .card_valid, .card_bad, .card_data, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
      .baud_sel, .disp_we, .disp_clear, .disp_pos, .disp_char, .page_show, .page_num, .beep,
      .nv_load_req, .nv_valid, .nv_rdata, .nv_store, .nv_wdata);
   kr_host_model host_u (.clk, .arst_n, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic [7:0] key_code(input logic [4:0] i);
      if (i < 5'h0A) return kr_pkg::DIGIT_BASE + 8'(i);
      if (i <= kr_pkg::IDX_FUNC_LAST) return kr_pkg::FUNC_BASE + 8'(i - kr_pkg::IDX_FUNC_ONE);
      if (i == kr_pkg::IDX_DOT) return kr_pkg::DOT_CODE;
      if (i == kr_pkg::IDX_BACKSPACE) return kr_pkg::BACKSPACE_CODE;
      if (i == kr_pkg::IDX_SUBMIT) return kr_pkg::SUBMIT_CODE;
      return kr_pkg::ERASE_ALL_CODE;
   endfunction
   // Results are checked at the falling edge, where registered outputs have settled
   always @(negedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         chk("tx_data", 32'(exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hXX), 32'(tx_data));
      if (disp_we === 1'b1 || disp_clear === 1'b1)
         chk("display", 32'(exp_disp.size() > 0 ? exp_disp.pop_front() : 14'h0XXX),
            32'({disp_clear, disp_we ? {disp_pos, disp_char} : 13'h0}));
   end
   task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk("readdata", e, q & m);
   endtask
   task automatic drain();
      repeat (4) @(posedge clk);
      while (exp_tx.size() > 0 || exp_disp.size() > 0) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   task automatic press(input logic [4:0] i);
      logic [7:0] c;
      c = key_code(i);
      if (kp_on && i == kr_pkg::IDX_BACKSPACE) begin
         if (cnt > 0) begin
            cnt--;
            void'(line.pop_back());
            exp_disp.push_back({1'b0, 5'(cnt), kr_pkg::BLANK_CHAR});
         end
      end else if (kp_on && (i == kr_pkg::IDX_ERASE_ALL || i == kr_pkg::IDX_SUBMIT)) begin
         // Submit ends a line only in buffered mode with keys held
         if (i == kr_pkg::IDX_ERASE_ALL || (buffered && cnt > 0)) begin
            if (i == kr_pkg::IDX_SUBMIT) foreach (line[k]) exp_tx.push_back(line[k]);
            exp_disp.push_back({1'b1, 13'h0});
            cnt = 0;
            line.delete();
         end
      end else if (kp_on && cnt < 32) begin
         exp_disp.push_back({cnt == 0, 5'(cnt), masked ? kr_pkg::MASK_CHAR : c});
         line.push_back(c);
         cnt++;
      end
      if (kp_on && !buffered) exp_tx.push_back(c);
      @(posedge clk);
      key_valid <= 1'b1;
      key_index <= i;
      @(posedge clk);
      key_valid <= 1'b0;
      drain();
   endtask
   task automatic card(input logic bad, input logic [7:0] d);
      @(posedge clk);
      card_valid <= 1'b1;
      card_bad <= bad;
      card_data <= d;
      @(posedge clk);
      card_valid <= 1'b0;
      card_data <= ~d;
      drain();
   endtask
   task automatic cmd(input logic [7:0] op, a1, a2, input int n, input logic [7:0] ans);
      exp_tx.push_back(ans);
      host_u.send_cmd(op, a1, a2, n);
      drain();
   endtask
   task automatic complete_run();
      chk("tx_left", 32'h0, 32'(exp_tx.size()));
      chk("disp_left", 32'h0, 32'(exp_disp.size()));
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // Stored byte has keypad and reader off; power-up must enable both anyway
      nv_valid <= 1'b1;
      nv_rdata <= 8'h02;
      @(posedge clk);
      nv_valid <= 1'b0;
      nv_rdata <= 8'hFD;
      repeat (3) @(posedge clk);
      rd(kr_pkg::REG_CTRL, 32'h2C, 32'h3F);
      rd(kr_pkg::REG_STATUS, 32'h0, 32'h3F);
      $display("test power_up done");
      for (int i = 0; i < 17; i++) press(5'(i));
      press(kr_pkg::IDX_BACKSPACE);
      rd(kr_pkg::REG_STATUS, 32'h10, 32'h3F);
      press(kr_pkg::IDX_ERASE_ALL);
      rd(kr_pkg::REG_STATUS, 32'h0, 32'h3F);
      $display("test unbuffered done");
      bus(1'b1, kr_pkg::REG_CTRL, 32'h1F);
      buffered = 1'b1;
      masked = 1'b1;
      bus(1'b1, 4'h8, 32'hFFFF_FFFF);
      rd(4'h8, 32'h0, 32'hFFFF_FFFF);
      rd(kr_pkg::REG_CTRL, 32'h1F, 32'h3F);
      for (int i = 0; i < 33; i++) press(5'($unsigned($random(seed)) % 10));
      rd(kr_pkg::REG_STATUS, 32'h20, 32'h3F);
      press(kr_pkg::IDX_SUBMIT);
      $display("test buffered done");
      press(5'h07);
      exp_disp.push_back({1'b1, 13'h0});
      exp_tx.push_back(kr_pkg::TIMEOUT_NOTICE);
      cnt = 0;
      line.delete();
      repeat (TMO + 40) @(posedge clk);
      rd(kr_pkg::REG_STATUS, 32'h0, 32'h3F);
      $display("test timeout done");
      press(5'h03);
      exp_disp.push_back({1'b1, 13'h0});
      cnt = 0;
      line.delete();
      cmd(kr_pkg::OP_ERASE, 8'h00, 8'h00, 0, kr_pkg::ANS_ACK);
      rd(kr_pkg::REG_STATUS, 32'h0, 32'h3F);
      cmd(8'h58, 8'h00, 8'h00, 0, kr_pkg::ANS_NACK);
      cmd(kr_pkg::OP_KEYPAD, kr_pkg::ARG_OFF, 8'h00, 1, kr_pkg::ANS_ACK);
      kp_on = 1'b0;
      press(5'h04);
      rd(kr_pkg::REG_STATUS, 32'h0, 32'h3F);
      kp_on = 1'b1;
      cmd(kr_pkg::OP_KEYPAD, kr_pkg::ARG_ON, 8'h00, 1, kr_pkg::ANS_ACK);
      $display("test host_commands done");
      q = 32'($random(seed));
      exp_tx.push_back(kr_pkg::CARD_TAG);
      exp_tx.push_back(q[7:0]);
      card(1'b0, q[7:0]);
      exp_tx.push_back(kr_pkg::CARD_ERR_NOTICE);
      card(1'b1, q[15:8]);
      cmd(kr_pkg::OP_READER, kr_pkg::ARG_OFF, 8'h00, 1, kr_pkg::ANS_ACK);
      card(1'b0, q[31:24]);
      bus(1'b1, kr_pkg::REG_CTRL, 32'h17);
      card(1'b0, q[23:16]);
      cmd(kr_pkg::OP_PARAM, kr_pkg::PARAM_DISP, kr_pkg::ARG_OFF, 2, kr_pkg::ANS_ACK);
      rd(kr_pkg::REG_CTRL, 32'h15, 32'h3F);
      $display("test reader done");
      complete_run();
   end
endmodule
